// ### cpc_checker.sv
// Purpose: receive, check and unpack fixed-format command packets
// Assumes: octet stream with a first-byte marker, inputs synchronous to clock_in
// Notes:   a result is held until result_ready_in; octets queue in the fifo meanwhile until it fills
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A packet is header, 64-bit timestamp, command identifier, six parameters and checkword, in that order.
// - The three version bits must be zero or the packet is malformed.
// - The packet-type bit must be one, marking a command.
// - The secondary-header flag must be one.
// - The 11-bit source identifier is passed on whatever its value and never causes rejection.
// - Both sequence-flag bits must be one, marking an unsegmented packet.
// - The data length field must read 23, the data field octets minus one.
// - The 64-bit timestamp is seconds then microseconds and is only passed on for logging.
// - The payload is always twelve bytes, six 16-bit argument words.
// - The two-byte checkword follows the sixth argument directly and ends the packet.
// - The 14-bit sequence count is captured for every complete packet; a truncated packet leaves it unchanged.
// - The checkword is recomputed over each complete packet and compared with the received one.
// - The checkword is CRC-CCITT, polynomial 1021, start FFFF, no reflection, final XOR zero, over all but itself.
module cpc_checker
  import cpc_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // octet stream from the link
  input  wire logic [7:0]  byte_data_in,
  input  wire logic        byte_first_in,
  input  wire logic        byte_valid_in,
  output logic             byte_ready_out,
  // result handshake
  input  wire logic        result_ready_in,
  output logic             cmd_valid_out,
  output logic             err_valid_out,
  // error causes
  output logic             err_header_out,
  output logic             err_length_out,
  output logic             err_crc_out,
  output logic             err_truncated_out,
  // unpacked fields
  output logic [10:0]      source_identifier_out,
  output logic [13:0]      seq_count_out,
  output logic [31:0]      ts_seconds_out,
  output logic [31:0]      ts_micros_out,
  output logic [15:0]      command_identifier_out,
  output logic [95:0]      params_out
);
  initial begin
    if (BUF_DEPTH < 2) begin
      $error("cpc_checker: BUF_DEPTH too small");
    end
  end

  // one octet through the CRC-CCITT register, msb first
  function automatic logic [15:0] crc_octet(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  cpc_state_t             state;
  cpc_state_t             next_state;
  logic [4:0]             index;
  logic [FRAME_BITS-9:0]  frame;
  logic [15:0]            crc;
  logic [8:0]             fifo_word;
  logic                   fifo_valid;
  logic                   fifo_ready;

  // the fifo decouples the link from a stalled result consumer
  cpc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    ({byte_first_in, byte_data_in}),
    .in_valid_in   (byte_valid_in),
    .in_ready_out  (byte_ready_out),
    .out_data_out  (fifo_word),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_ready)
  );

  wire        w_first  = fifo_word[8];
  wire [7:0]  w_byte   = fifo_word[7:0];
  // a first marker inside a packet is left in the fifo to start the next one
  wire        restart  = (state == CPC_BODY) & fifo_valid & w_first;
  assign fifo_ready    = (state == CPC_IDLE) | ((state == CPC_BODY) & ~w_first);
  wire        take     = fifo_valid & fifo_ready;
  wire        start    = take & (state == CPC_IDLE) & w_first;
  wire        body     = take & (state == CPC_BODY);
  wire        last     = body & (index == 5'(FRAME_BYTES - 1));
  wire [FRAME_BITS-1:0] full = {frame, w_byte};

  wire [2:0]  f_version = full[POS_VERSION +: 3];
  wire        f_type    = full[POS_TYPE];
  wire        f_sec_hdr = full[POS_SEC_HDR];
  wire [1:0]  f_flags   = full[POS_SEQ_FLAGS +: 2];
  wire [15:0] f_length  = full[POS_LENGTH +: 16];
  wire [15:0] f_crc     = full[POS_CRC +: 16];

  wire bad_version = f_version != VERSION_VALUE;
  wire bad_type    = f_type != TYPE_COMMAND;
  wire bad_sec     = f_sec_hdr != SEC_HDR_VALUE;
  wire bad_flags   = f_flags != SEQ_FLAGS_VAL;
  wire bad_header  = bad_version | bad_type | bad_sec | bad_flags;
  wire bad_length  = f_length != LENGTH_VALUE;
  wire bad_crc     = (crc ^ CRC_XOR_OUT) != f_crc;
  wire good        = ~bad_header & ~bad_length & ~bad_crc;

  always_comb begin
    next_state = state;
    unique case (state)
      CPC_IDLE: begin
        if (start) begin
          next_state = CPC_BODY;
        end
      end
      CPC_BODY: begin
        if (last || restart) begin
          next_state = CPC_HOLD;
        end
      end
      CPC_HOLD: begin
        if (result_ready_in) begin
          next_state = CPC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= CPC_IDLE;
      index <= 5'h00;
      frame <= '0;
      crc   <= CRC_INIT;
    end else begin
      state <= next_state;
      if (start) begin
        index <= 5'h01;
        frame <= {{(FRAME_BITS - 16){1'b0}}, w_byte};
        crc   <= crc_octet(CRC_INIT, w_byte);
      end else if (body) begin
        index <= index + 5'h01;
        frame <= full[FRAME_BITS-9:0];
        if (index < 5'(CRC_END_BYTE)) begin
          crc <= crc_octet(crc, w_byte);
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cmd_valid_out          <= 1'b0;
      err_valid_out          <= 1'b0;
      err_header_out         <= 1'b0;
      err_length_out         <= 1'b0;
      err_crc_out            <= 1'b0;
      err_truncated_out      <= 1'b0;
      source_identifier_out  <= 11'h000;
      seq_count_out          <= 14'h0000;
      ts_seconds_out         <= 32'h00000000;
      ts_micros_out          <= 32'h00000000;
      command_identifier_out <= 16'h0000;
      params_out             <= '0;
    end else if (last) begin
      cmd_valid_out          <= good;
      err_valid_out          <= ~good;
      err_header_out         <= bad_header;
      err_length_out         <= bad_length;
      err_crc_out            <= bad_crc;
      err_truncated_out      <= 1'b0;
      source_identifier_out  <= full[POS_SOURCE +: 11];
      seq_count_out          <= full[POS_SEQ_COUNT +: 14];
      ts_seconds_out         <= full[POS_TS_SEC +: 32];
      ts_micros_out          <= full[POS_TS_USEC +: 32];
      command_identifier_out <= good ? full[POS_COMMAND +: 16] : 16'h0000;
      params_out             <= good ? full[POS_PARAMS +: 96] : 96'h0;
    end else if (restart) begin
      // short packets cannot be checked, so they are flagged like any bad one
      cmd_valid_out          <= 1'b0;
      err_valid_out          <= 1'b1;
      err_header_out         <= 1'b0;
      err_length_out         <= 1'b0;
      err_crc_out            <= 1'b0;
      err_truncated_out      <= 1'b1;
      command_identifier_out <= 16'h0000;
      params_out             <= '0;
    end else if (state == CPC_HOLD && result_ready_in) begin
      cmd_valid_out          <= 1'b0;
      err_valid_out          <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### cpc_pkg.sv
// Purpose: shared constants for the command packet checker
// Assumes: packets arrive as octets, most significant first
// Notes:   bit positions refer to the 240-bit assembled frame, byte 0 on top
package cpc_pkg;
  localparam int unsigned FRAME_BYTES   = 30;
  localparam int unsigned CRC_END_BYTE  = 28;
  localparam int unsigned FIFO_WIDTH    = 9;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned FRAME_BITS    = 240;

  localparam logic [2:0]  VERSION_VALUE = 3'h0;
  localparam logic        TYPE_COMMAND  = 1'h1;
  localparam logic        SEC_HDR_VALUE = 1'h1;
  localparam logic [1:0]  SEQ_FLAGS_VAL = 2'h3;
  localparam logic [15:0] LENGTH_VALUE  = 16'h0017;

  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_XOR_OUT   = 16'h0000;

  localparam int unsigned POS_VERSION   = 237;
  localparam int unsigned POS_TYPE      = 236;
  localparam int unsigned POS_SEC_HDR   = 235;
  localparam int unsigned POS_SOURCE    = 224;
  localparam int unsigned POS_SEQ_FLAGS = 222;
  localparam int unsigned POS_SEQ_COUNT = 208;
  localparam int unsigned POS_LENGTH    = 192;
  localparam int unsigned POS_TS_SEC    = 160;
  localparam int unsigned POS_TS_USEC   = 128;
  localparam int unsigned POS_COMMAND   = 112;
  localparam int unsigned POS_PARAMS    = 16;
  localparam int unsigned POS_CRC       = 0;

  typedef enum logic [1:0] {
    CPC_IDLE,
    CPC_BODY,
    CPC_HOLD
  } cpc_state_t;
endpackage

// ### cpc_fifo.sv
// Purpose: small show-ahead fifo with a registered output word
// Assumes: one clock, synchronous active-low reset
// Notes:   holds DEPTH words in memory plus one in the output register
`timescale 1ns/1ps
`default_nettype none
module cpc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("cpc_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              write_en  = in_valid_in & in_ready_out;
  wire              load_en   = (~out_valid_out | out_ready_in) & (count != '0);
  wire  [CW-1:0]    next_count = count + CW'(write_en) - CW'(load_en);

  always_ff @(posedge clock_in) begin
    if (write_en) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else begin
      wr_ptr       <= wr_ptr + AW'(write_en);
      rd_ptr       <= rd_ptr + AW'(load_en);
      count        <= next_count;
      // ready is registered, so it looks one word ahead
      in_ready_out <= next_count < CW'(DEPTH);
      if (load_en) begin
        out_data_out  <= mem[rd_ptr];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### cpc_checker_sva.sv
// Purpose: port checker for the command packet checker
// Assumes: bound to cpc_checker, one clock domain
// Notes:   error causes are judged only while err_valid_out stands
`timescale 1ns/1ps
`default_nettype none
module cpc_checker_sva (
  // clock and reset
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  // handshakes
  input wire logic        byte_ready_out,
  input wire logic        result_ready_in,
  input wire logic        cmd_valid_out,
  input wire logic        err_valid_out,
  // verdict and fields
  input wire logic        err_header_out,
  input wire logic        err_length_out,
  input wire logic        err_crc_out,
  input wire logic        err_truncated_out,
  input wire logic [13:0] seq_count_out,
  input wire logic [15:0] command_identifier_out,
  input wire logic [95:0] params_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire any_valid = cmd_valid_out | err_valid_out;
  a_one_verdict: assert property (!(cmd_valid_out && err_valid_out)) else $error("both verdicts high");
  a_result_holds: assert property (any_valid && !result_ready_in |=>
    $stable({cmd_valid_out, err_valid_out, seq_count_out, command_identifier_out, params_out}))
    else $error("held result changed");
  a_result_drops: assert property (any_valid && result_ready_in |=> !any_valid) else $error("result not taken");
  a_err_cause: assert property (err_valid_out |->
    (err_header_out || err_length_out || err_crc_out || err_truncated_out)) else $error("error without cause");
  a_err_zeroed: assert property (err_valid_out |->
    command_identifier_out == 16'h0 && params_out == 96'h0) else $error("bad packet forwarded");
  a_trunc_alone: assert property (err_valid_out && err_truncated_out |->
    !(err_header_out || err_length_out || err_crc_out)) else $error("truncation mixed with checks");
  a_cmd_spacing: assert property ($fell(cmd_valid_out) |-> !cmd_valid_out [*8]) else $error("results too close");
  a_ready_wakes: assert property ($rose(rst_n_in) |-> !byte_ready_out ##1 byte_ready_out)
    else $error("stream not ready after reset");
endmodule
bind cpc_checker cpc_checker_sva u_sva (.clock_in(clock_in), .rst_n_in(rst_n_in), .byte_ready_out(byte_ready_out),
  .result_ready_in(result_ready_in), .cmd_valid_out(cmd_valid_out), .err_valid_out(err_valid_out),
  .err_header_out(err_header_out), .err_length_out(err_length_out), .err_crc_out(err_crc_out),
  .err_truncated_out(err_truncated_out), .seq_count_out(seq_count_out),
  .command_identifier_out(command_identifier_out), .params_out(params_out));
`default_nettype wire

// ### cpc_host.sv
// Purpose: host vehicle model sending command octets
// Assumes: called right after a rising edge
// Notes:   released data shows the inverse of the last octet
`timescale 1ns/1ps
`default_nettype none
module cpc_host (
  // clock
  input  wire logic       clock_in,
  // octet stream
  input  wire logic       byte_ready_in,
  output logic      [7:0] byte_data_out,
  output logic            byte_first_out,
  output logic            byte_valid_out
);
  initial begin
    byte_data_out = 8'hA5;
    byte_first_out = 1'b0;
    byte_valid_out = 1'b0;
  end
  task automatic send(input logic [239:0] f, input int n);
    int i;
    i = 0;
    while (i < n) begin
      byte_data_out <= f[239-8*i -: 8];
      byte_first_out <= (i == 0);
      byte_valid_out <= 1'b1;
      @(posedge clock_in);
      if (byte_ready_in === 1'b1) i++;
    end
  endtask
  task automatic idle();
    byte_valid_out <= 1'b0;
    byte_first_out <= 1'b0;
    byte_data_out <= ~byte_data_out;
  endtask
endmodule
`default_nettype wire

// ### test_command_packet_checker.sv
// Purpose: self-checking bench for the command packet checker
// Assumes: default fifo depth, host model on the octet stream
// Notes:   the fifo holds 17 octets, so a held verdict stalls the host
`timescale 1ns/1ps
`default_nettype none
module test_command_packet_checker;
  import cpc_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        result_ready_in = 1'b0;
  logic [7:0]  byte_data_in;
  logic        byte_first_in, byte_valid_in, byte_ready_out, cmd_valid_out, err_valid_out;
  logic        err_header_out, err_length_out, err_crc_out, err_truncated_out;
  logic [10:0] source_identifier_out;
  logic [13:0] seq_count_out;
  logic [31:0] ts_seconds_out, ts_micros_out;
  logic [15:0] command_identifier_out;
  logic [95:0] params_out;
  logic [239:0] fr, g;
  int bad_count = 0, checked = 0, cyc = 0;
  cpc_host host (.clock_in, .byte_ready_in(byte_ready_out), .byte_data_out(byte_data_in),
    .byte_first_out(byte_first_in), .byte_valid_out(byte_valid_in));
  cpc_checker #(.BUF_DEPTH(16)) uut (.clock_in, .rst_n_in, .byte_data_in, .byte_first_in, .byte_valid_in,
    .byte_ready_out, .result_ready_in, .cmd_valid_out, .err_valid_out, .err_header_out, .err_length_out,
    .err_crc_out, .err_truncated_out, .source_identifier_out, .seq_count_out, .ts_seconds_out, .ts_micros_out,
    .command_identifier_out, .params_out);
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // frame with the checkword computed over octets 0 to 27
  function automatic logic [239:0] mk(input logic [2:0] v, input logic t, s, input logic [10:0] src,
                                      input logic [1:0] fl, input logic [13:0] sq, input logic [15:0] len);
    logic [239:0] f;
    logic [15:0] c;
    f = {v, t, s, src, fl, sq, len, 18'h1, sq, 18'h2, sq, 2'b0, sq,
         96'hA001B002C003D004E005F006 ^ {6{2'b00, sq}}, 16'h0};
    c = CRC_INIT;
    for (int i = 239; i >= 16; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ f[i]) ? CRC_POLY : 16'h0);
    f[15:0] = c ^ CRC_XOR_OUT;
    return f;
  endfunction
  // kind is {cmd, err, header, length, crc, truncated}
  task automatic get(input int stall, input logic [5:0] kind);
    int n;
    n = 0;
    // step past the edge first, so a result taken just before is seen as gone
    @(posedge clock_in);
    #1;
    while (!(cmd_valid_out === 1'b1 || err_valid_out === 1'b1) && n < 400) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    repeat (stall) @(posedge clock_in);
    #1;
    check({cmd_valid_out, err_valid_out, err_header_out, err_length_out, err_crc_out, err_truncated_out}, kind);
    if (!kind[0]) check({source_identifier_out, seq_count_out, ts_seconds_out, ts_micros_out},
                        {fr[234:224], fr[221:208], fr[191:128]});
    if (!kind[0]) check({command_identifier_out, params_out}, kind[5] ? fr[127:16] : 112'h0);
    @(posedge clock_in);
    result_ready_in <= 1'b1;
    @(posedge clock_in);
    result_ready_in <= 1'b0;
  endtask
  task automatic run(input int stall, input logic [5:0] kind);
    host.send(fr, 30);
    host.idle();
    get(stall, kind);
  endtask
  task automatic t_good;
    fr = mk(3'h0, 1'b1, 1'b1, 11'h7FF, 2'h3, 14'h3FFF, 16'h0017);
    run(0, 6'b100000);
  endtask
  task automatic t_header;
    for (int k = 0; k < 7; k++) begin
      fr = mk(k == 0 ? 3'h1 : k == 1 ? 3'h4 : 3'h0, k != 2, k != 3, 11'h0, k < 4 ? 2'h3 : 2'(k - 4),
              14'(k), 16'h0017);
      run(0, 6'b011000);
    end
  endtask
  task automatic t_length;
    for (int k = 0; k < 3; k++) begin
      fr = mk(3'h0, 1'b1, 1'b1, 11'h0, 2'h3, 14'h10, k == 0 ? 16'h0016 : k == 1 ? 16'h0018 : 16'h0);
      run(0, 6'b010100);
    end
  endtask
  task automatic t_crc;
    fr = mk(3'h0, 1'b1, 1'b1, 11'h1, 2'h3, 14'h20, 16'h0017);
    fr[0] = ~fr[0];
    run(0, 6'b010010);
    fr = mk(3'h0, 1'b1, 1'b1, 11'h1, 2'h3, 14'h21, 16'h0017);
    fr[100] = ~fr[100];
    run(0, 6'b010010);
  endtask
  task automatic t_trunc;
    g = mk(3'h0, 1'b1, 1'b1, 11'h2, 2'h3, 14'h30, 16'h0017);
    fr = mk(3'h0, 1'b1, 1'b1, 11'h3, 2'h3, 14'h31, 16'h0017);
    fork
      begin
        host.send(g, 10);
        host.send(fr, 30);
        host.idle();
      end
    join_none
    get(40, 6'b010001);
    #1;
    check(byte_ready_out, 1'b0);
    get(0, 6'b100000);
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_good();
    t_header();
    t_length();
    t_crc();
    t_trunc();
    end_of_test();
  end
endmodule
`default_nettype wire
